/* core/incjb_defines.vh */
/*
 * Constants for the increment and jump-if-bit-set decode slice:
 * opcode bytes, field patterns, register indices and state counts.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef INCJB_DEFINES_VH
`define INCJB_DEFINES_VH

// Opcode bytes and field patterns
`define OP_ESCAPE 8'hA5
`define OP_INC_SHORT 8'h0B
`define OP_INC_POINTER 8'hA3
`define OP_JB_LEGACY 8'h20
`define OP_PAGE_BIT 8'hA9
`define OP_JB_EXT_HI 5'h04
`define INC_DWORD_MARK 2'h3

// Dword register holding the data pointer in its low word
`define DWORD_REG_FIFTYSIX 4'hE

// States per instruction, binary and source opcode mode
`define ST_INC_DWORD_BIN 3'h4
`define ST_INC_DWORD_SRC 3'h3
`define ST_INC_POINTER 3'h1
`define ST_JB_LEGACY_NT 3'h2
`define ST_JB_EXT_BIN_NT 3'h4
`define ST_JB_EXT_SRC_NT 3'h3
`define ST_JB_TAKEN_EXTRA 3'h3

// Instruction kinds
`define KIND_INC_DWORD 2'h0
`define KIND_INC_POINTER 2'h1
`define KIND_JB_LEGACY 2'h2
`define KIND_JB_EXT 2'h3

`endif

/* core/dword_file.v */
/*
 * Sixteen dword registers with one registered read port and one write port.
 * Assumes the caller holds the read address only in the cycle it pulses rd_en_in.
 */
module dword_file (
    input wire clock_in,
    input wire rd_en_in,
    input wire [3:0] rd_index_in,
    output reg [31:0] rd_data_out,
    input wire wr_en_in,
    input wire [3:0] wr_index_in,
    input wire [31:0] wr_data_in
);
    reg [31:0] mem [0:15];

    // Read data holds until the next read, so execution may take several states
    always @(posedge clock_in) begin
        if (wr_en_in) begin
            mem[wr_index_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem[rd_index_in];
        end
    end
endmodule

/* core/incjb_decode.v */
/*
 * Decode and execute for dword increment by short, data pointer increment
 * and jump-if-bit-set in its legacy and extended bit address forms.
 * Assumes one instruction byte per cycle on the fetch port, and that the
 * bit addressed by bit_req_out is returned on bit_value_in in the same cycle.
 */
// Operation
// - Dword increment by short: 0B, then register, marker 11, two-bit short
// - Binary mode needs escape A5 before 0B; source mode needs none
// - Data pointer adds one modulo 65536, low byte carries into high byte
// - High byte rollover never carries into the pointer extension byte
// - Pointer increment is A3 alone, both modes, one byte, one state
// - Jump: advance PC past instruction, then add displacement if bit set
// - Legacy jump is 20, bit address, displacement; three bytes both modes
// - Legacy jump takes 2 states not taken, 5 taken, both modes
// - Extended jump: binary 5 bytes 4/7 states; source 4 bytes 3/6
`include "incjb_defines.vh"

module incjb_decode (
    input wire clock_in,
    input wire nrst_in,
    input wire source_mode_in,
    input wire [7:0] fetch_byte_in,
    input wire fetch_valid_in,
    output reg fetch_ready_out,
    input wire bit_value_in,
    input wire load_en_in,
    input wire [3:0] load_index_in,
    input wire [31:0] load_data_in,
    output reg bit_req_out,
    output reg [7:0] bit_addr_out,
    output reg [2:0] bit_pos_out,
    output reg bit_ext_out,
    output reg done_out,
    output reg illegal_out,
    output reg taken_out,
    output reg [15:0] pc_out,
    output reg result_we_out,
    output reg [3:0] result_index_out,
    output reg [31:0] result_out,
    output reg flag_n_out,
    output reg flag_z_out
);
    localparam S_IDLE = 5'h01;
    localparam S_PREFIX = 5'h02;
    localparam S_PAGE = 5'h04;
    localparam S_OPND = 5'h08;
    localparam S_EXEC = 5'h10;

    reg [4:0] state_q;
    reg [1:0] kind_q;
    reg [2:0] len_q;
    reg op_left_q;
    reg [2:0] cnt_q;
    reg first_q;
    reg [3:0] idx_q;
    reg [1:0] short_q;
    reg [7:0] rel_q;

    wire take = fetch_valid_in & fetch_ready_out;
    wire [31:0] rd_data;
    wire rd_en;
    wire [3:0] rd_index;
    reg wr_en;
    reg [31:0] wr_data;
    wire [3:0] wr_index;

    // Sign-extended displacement added to an already advanced PC
    function [15:0] pc_step;
        input [15:0] pc;
        input [2:0] len;
        input [7:0] rel;
        input taken;
        begin
            pc_step = pc + {13'h0000, len};
            if (taken) begin
                pc_step = pc_step + {{8{rel[7]}}, rel};
            end
        end
    endfunction

    // Register read is started by the byte that ends the fetch
    assign rd_en = take & (((state_q == S_IDLE) & (fetch_byte_in == `OP_INC_POINTER)) |
        ((state_q == S_OPND) & (kind_q == `KIND_INC_DWORD)));
    assign rd_index = (state_q == S_IDLE) ? `DWORD_REG_FIFTYSIX : fetch_byte_in[7:4];
    assign wr_index = wr_en ? idx_q : load_index_in;

    always @* begin
        wr_en = 1'b0;
        wr_data = load_data_in;
        if ((state_q == S_EXEC) && (cnt_q == 3'h0) && !kind_q[1]) begin
            wr_en = 1'b1;
            if (kind_q == `KIND_INC_DWORD) begin
                // Short field codes the step 1, 2, 4 or 8, not the value added
                wr_data = rd_data + (32'h00000001 << short_q);
            end else begin
                wr_data = {rd_data[31:16], rd_data[15:0] + 16'h0001};
            end
        end
    end

    dword_file u_dword_file (
        .clock_in(clock_in),
        .rd_en_in(rd_en),
        .rd_index_in(rd_index),
        .rd_data_out(rd_data),
        .wr_en_in(wr_en | load_en_in),
        .wr_index_in(wr_index),
        .wr_data_in(wr_data)
    );

    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= S_IDLE;
            kind_q <= `KIND_INC_DWORD;
            len_q <= 3'h0;
            op_left_q <= 1'b0;
            cnt_q <= 3'h0;
            first_q <= 1'b0;
            idx_q <= 4'h0;
            short_q <= 2'h0;
            rel_q <= 8'h00;
            fetch_ready_out <= 1'b1;
            bit_req_out <= 1'b0;
            bit_addr_out <= 8'h00;
            bit_pos_out <= 3'h0;
            bit_ext_out <= 1'b0;
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            taken_out <= 1'b0;
            pc_out <= 16'h0000;
            result_we_out <= 1'b0;
            result_index_out <= 4'h0;
            result_out <= 32'h00000000;
            flag_n_out <= 1'b0;
            flag_z_out <= 1'b0;
        end else begin
            bit_req_out <= 1'b0;
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            result_we_out <= 1'b0;
            first_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        len_q <= 3'h1;
                        if (fetch_byte_in == `OP_ESCAPE && !source_mode_in) begin
                            state_q <= S_PREFIX;
                        end else if (fetch_byte_in == `OP_INC_SHORT && source_mode_in) begin
                            kind_q <= `KIND_INC_DWORD;
                            op_left_q <= 1'b0;
                            state_q <= S_OPND;
                        end else if (fetch_byte_in == `OP_INC_POINTER) begin
                            kind_q <= `KIND_INC_POINTER;
                            idx_q <= `DWORD_REG_FIFTYSIX;
                            cnt_q <= `ST_INC_POINTER - 3'h1;
                            fetch_ready_out <= 1'b0;
                            state_q <= S_EXEC;
                        end else if (fetch_byte_in == `OP_JB_LEGACY) begin
                            kind_q <= `KIND_JB_LEGACY;
                            op_left_q <= 1'b1;
                            state_q <= S_OPND;
                        end else if (fetch_byte_in == `OP_PAGE_BIT && source_mode_in) begin
                            state_q <= S_PAGE;
                        end else begin
                            illegal_out <= 1'b1;
                        end
                    end
                end
                S_PREFIX: begin
                    if (take) begin
                        len_q <= len_q + 3'h1;
                        if (fetch_byte_in == `OP_INC_SHORT) begin
                            kind_q <= `KIND_INC_DWORD;
                            op_left_q <= 1'b0;
                            state_q <= S_OPND;
                        end else if (fetch_byte_in == `OP_PAGE_BIT) begin
                            state_q <= S_PAGE;
                        end else begin
                            illegal_out <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_PAGE: begin
                    if (take) begin
                        len_q <= len_q + 3'h1;
                        if (fetch_byte_in[7:3] == `OP_JB_EXT_HI) begin
                            kind_q <= `KIND_JB_EXT;
                            bit_pos_out <= fetch_byte_in[2:0];
                            op_left_q <= 1'b1;
                            state_q <= S_OPND;
                        end else begin
                            illegal_out <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_OPND: begin
                    if (take) begin
                        len_q <= len_q + 3'h1;
                        op_left_q <= 1'b0;
                        if (kind_q == `KIND_INC_DWORD) begin
                            if (fetch_byte_in[3:2] == `INC_DWORD_MARK) begin
                                idx_q <= fetch_byte_in[7:4];
                                short_q <= fetch_byte_in[1:0];
                                fetch_ready_out <= 1'b0;
                                state_q <= S_EXEC;
                                if (source_mode_in) begin
                                    cnt_q <= `ST_INC_DWORD_SRC - 3'h1;
                                end else begin
                                    cnt_q <= `ST_INC_DWORD_BIN - 3'h1;
                                end
                            end else begin
                                illegal_out <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        end else if (op_left_q) begin
                            bit_addr_out <= fetch_byte_in;
                            bit_ext_out <= (kind_q == `KIND_JB_EXT);
                            if (kind_q == `KIND_JB_LEGACY) begin
                                bit_pos_out <= 3'h0;
                            end
                        end else begin
                            rel_q <= fetch_byte_in;
                            bit_req_out <= 1'b1;
                            first_q <= 1'b1;
                            fetch_ready_out <= 1'b0;
                            state_q <= S_EXEC;
                            if (kind_q == `KIND_JB_LEGACY) begin
                                cnt_q <= `ST_JB_LEGACY_NT - 3'h1;
                            end else if (source_mode_in) begin
                                cnt_q <= `ST_JB_EXT_SRC_NT - 3'h1;
                            end else begin
                                cnt_q <= `ST_JB_EXT_BIN_NT - 3'h1;
                            end
                        end
                    end
                end
                S_EXEC: begin
                    if (first_q && kind_q[1]) begin
                        // The bit decides how many states the jump takes
                        taken_out <= bit_value_in;
                        if (bit_value_in) begin
                            cnt_q <= cnt_q - 3'h1 + `ST_JB_TAKEN_EXTRA;
                        end else begin
                            cnt_q <= cnt_q - 3'h1;
                        end
                    end else if (cnt_q != 3'h0) begin
                        cnt_q <= cnt_q - 3'h1;
                    end else begin
                        done_out <= 1'b1;
                        fetch_ready_out <= 1'b1;
                        state_q <= S_IDLE;
                        if (kind_q[1]) begin
                            pc_out <= pc_step(pc_out, len_q, rel_q, taken_out);
                        end else begin
                            pc_out <= pc_step(pc_out, len_q, rel_q, 1'b0);
                            result_we_out <= 1'b1;
                            result_index_out <= idx_q;
                            result_out <= wr_data;
                            if (kind_q == `KIND_INC_DWORD) begin
                                flag_n_out <= wr_data[31];
                                flag_z_out <= (wr_data == 32'h00000000);
                            end else begin
                                flag_n_out <= wr_data[15];
                                flag_z_out <= (wr_data[15:0] == 16'h0000);
                            end
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    fetch_ready_out <= 1'b1;
                end
            endcase
        end
    end
endmodule

/* testbench/incjb_decode_chk.sv */
/* Port-timing checker for incjb_decode, bound to every instance.
   Assumes one clock and an active-low asynchronous reset. */
module incjb_decode_chk (
    input logic clock_in,
    input logic nrst_in,
    input logic fetch_ready_out,
    input logic bit_value_in,
    input logic bit_req_out,
    input logic bit_ext_out,
    input logic done_out,
    input logic illegal_out,
    input logic taken_out,
    input logic [15:0] pc_out,
    input logic result_we_out,
    input logic flag_n_out,
    input logic flag_z_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_taken;
        bit_req_out && bit_value_in;
    endsequence
    sequence s_long_wait;
        !done_out [*4] ##1 done_out;
    endsequence
    sequence s_flags_kept;
        $stable(flag_n_out) && $stable(flag_z_out);
    endsequence
    chk_done_pulse: assert property (done_out |=> !done_out)
        else $error("done held");
    chk_req_no_fetch: assert property (bit_req_out |-> !fetch_ready_out)
        else $error("fetch open during bit request");
    chk_done_ready: assert property (done_out |-> fetch_ready_out)
        else $error("fetch closed at done");
    chk_we_with_done: assert property (result_we_out |-> done_out)
        else $error("writeback outside done");
    chk_taken_state: assert property (bit_req_out |=> taken_out == $past(bit_value_in))
        else $error("taken state wrong");
    chk_legacy_taken: assert property (s_taken ##0 !bit_ext_out |=> s_long_wait)
        else $error("legacy taken timing");
    chk_legacy_skip: assert property (bit_req_out && !bit_value_in && !bit_ext_out |=> !done_out ##1 done_out)
        else $error("legacy not taken timing");
    chk_taken_extra: assert property (s_taken |=> !done_out [*3])
        else $error("taken jump ended early");
    chk_jump_flags: assert property (bit_req_out |-> s_flags_kept ##1 s_flags_kept [*5])
        else $error("flags moved by jump");
    chk_pc_on_done: assert property (!done_out |-> $stable(pc_out))
        else $error("pc moved without done");
    chk_illegal_quiet: assert property (illegal_out |-> !done_out && !result_we_out)
        else $error("illegal with completion");
endmodule

bind incjb_decode incjb_decode_chk chk_i (.clock_in(clock_in), .nrst_in(nrst_in),
    .fetch_ready_out(fetch_ready_out), .bit_value_in(bit_value_in),
    .bit_req_out(bit_req_out), .bit_ext_out(bit_ext_out), .done_out(done_out),
    .illegal_out(illegal_out), .taken_out(taken_out), .pc_out(pc_out),
    .result_we_out(result_we_out), .flag_n_out(flag_n_out), .flag_z_out(flag_z_out));

/* testbench/incjb_decode_tb.sv */
/* Self-checking bench for incjb_decode with an integer model.
   Assumes the design files and incjb_defines.vh are compiled alongside. */
`include "incjb_defines.vh"
module incjb_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in = 0, nrst_in = 0, source_mode_in = 0, fetch_valid_in = 0;
    logic bit_value_in = 0, load_en_in = 0, fetch_ready_out, bit_req_out, bit_ext_out;
    logic done_out, illegal_out, taken_out, result_we_out, flag_n_out, flag_z_out, ee;
    logic [7:0] fetch_byte_in = 8'h00, bit_addr_out, ea;
    logic [3:0] load_index_in = 4'h0, result_index_out;
    logic [31:0] load_data_in = 32'h00000000, result_out, rf [16];
    logic [2:0] bit_pos_out, ep;
    logic [15:0] pc_out, pc = 16'h0000, lf = 16'h003B;
    // Done shows at the falling edge one past the state count after the last byte
    int bad_count = 0, n_compared = 0, cyc = 0, base_i = 1, base_j = 1;
    incjb_decode dut (.clock_in(clock_in), .nrst_in(nrst_in), .source_mode_in(source_mode_in),
        .fetch_byte_in(fetch_byte_in), .fetch_valid_in(fetch_valid_in),
        .fetch_ready_out(fetch_ready_out), .bit_value_in(bit_value_in),
        .load_en_in(load_en_in), .load_index_in(load_index_in), .load_data_in(load_data_in),
        .bit_req_out(bit_req_out), .bit_addr_out(bit_addr_out), .bit_pos_out(bit_pos_out),
        .bit_ext_out(bit_ext_out), .done_out(done_out), .illegal_out(illegal_out),
        .taken_out(taken_out), .pc_out(pc_out), .result_we_out(result_we_out),
        .result_index_out(result_index_out), .result_out(result_out),
        .flag_n_out(flag_n_out), .flag_z_out(flag_z_out));
    always #50 clock_in = ~clock_in;
    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task nx;
        lf = lfsr_next(lf);
    endtask
    task put(input logic [7:0] b);
        @(negedge clock_in);
        while (!fetch_ready_out) @(negedge clock_in);
        fetch_valid_in = 1;
        fetch_byte_in = b;
        @(posedge clock_in);
    endtask
    task ld(input logic [3:0] r, input logic [31:0] d);
        @(negedge clock_in);
        load_en_in = 1;
        load_index_in = r;
        load_data_in = d;
        @(negedge clock_in);
        load_en_in = 0;
        rf[r] = d;
    endtask
    // Offers junk while busy, so a refused byte that slips in shows up
    task fin(input logic want, output int n);
        n = 0;
        forever begin
            @(negedge clock_in);
            n++;
            nx;
            if (done_out || illegal_out || n > 40) break;
            fetch_valid_in = !fetch_ready_out;
            fetch_byte_in = lf[7:0];
            bit_value_in = bit_req_out ? want : !want;
            if (bit_req_out) begin
                chk(bit_addr_out, ea);
                chk({bit_ext_out, bit_pos_out}, {ee, ep});
            end
        end
        fetch_valid_in = 0;
    endtask
    task do_ptr;
        int n;
        put(`OP_INC_POINTER);
        fin(0, n);
        rf[14][15:0] = rf[14][15:0] + 16'h0001;
        pc = pc + 16'h0001;
        chk(n - base_i, 1);
        chk({result_we_out, result_index_out, result_out}, {1'b1, 4'hE, rf[14]});
        chk({flag_n_out, flag_z_out}, {rf[14][15], rf[14][15:0] == 16'h0000});
        chk(pc_out, pc);
    endtask
    task do_inc(input logic [3:0] r, input logic [1:0] v);
        int n;
        if (!source_mode_in) put(`OP_ESCAPE);
        put(`OP_INC_SHORT);
        put({r, `INC_DWORD_MARK, v});
        fin(0, n);
        rf[r] = rf[r] + (32'h00000001 << v);
        pc = pc + (source_mode_in ? 16'h0002 : 16'h0003);
        chk(n - base_i, source_mode_in ? 3 : 4);
        chk({result_we_out, result_index_out, result_out}, {1'b1, r, rf[r]});
        chk({flag_n_out, flag_z_out}, {rf[r][31], rf[r] == 32'h00000000});
        chk(pc_out, pc);
    endtask
    task do_jb(input logic ext, input logic [7:0] a, input logic [2:0] p,
        input logic [7:0] rel, input logic b);
        int n, st;
        logic [1:0] fl;
        fl = {flag_n_out, flag_z_out};
        ea = a;
        ep = ext ? p : 3'h0;
        ee = ext;
        if (ext) begin
            if (!source_mode_in) put(`OP_ESCAPE);
            put(`OP_PAGE_BIT);
            put({`OP_JB_EXT_HI, p});
        end else begin
            put(`OP_JB_LEGACY);
        end
        put(a);
        put(rel);
        fin(b, n);
        pc = pc + (ext ? (source_mode_in ? 16'h0004 : 16'h0005) : 16'h0003);
        if (b) pc = pc + {{8{rel[7]}}, rel};
        st = (ext ? (source_mode_in ? 3 : 4) : 2) + (b ? 3 : 0);
        chk(n - base_j, st);
        chk({done_out, taken_out, pc_out}, {1'b1, b, pc});
        chk({flag_n_out, flag_z_out}, fl);
    endtask
    task bad(input logic [23:0] s, input int c);
        int n;
        for (int i = 0; i < c; i++) put(s[8 * i +: 8]);
        fin(0, n);
        chk({illegal_out, pc_out}, {1'b1, pc});
    endtask
    initial begin
        repeat (2) @(negedge clock_in);
        chk({fetch_ready_out, done_out, pc_out}, {1'b1, 1'b0, 16'h0000});
        nrst_in = 1;
        for (int i = 0; i < 16; i++) begin
            nx;
            ld(i[3:0], {lf, lf ^ 16'h5A5A});
        end
        ld(4'hE, 32'hABCD12FE);
        repeat (3) do_ptr;
        ld(4'hE, 32'hABCDFFFF);
        do_ptr;
        for (int m = 0; m < 2; m++) begin
            @(negedge clock_in);
            source_mode_in = m[0];
            ld(4'h7, 32'hFFFFFFFE);
            do_inc(4'h7, 2'h2);
            for (int v = 0; v < 3; v++) begin
                nx;
                do_inc(lf[3:0], v[1:0]);
            end
            for (int k = 0; k < 8; k++) begin
                nx;
                do_jb(k[1], lf[7:0], lf[10:8], lf[15:8], k[0]);
            end
            do_ptr;
            if (m == 0) bad(24'h00000B, 1);
            else bad(24'h0000A5, 1);
            bad(m == 0 ? 24'h30A9A5 : 24'h0030A9, m == 0 ? 3 : 2);
            bad(24'h00000B, 2);
        end
        close_out();
    end
endmodule
